/* rtl/acr_pkg.sv */
package acr_pkg;

  localparam int unsigned DATA_W        = 12;
  localparam int unsigned WORD_W        = DATA_W + 1;
  localparam int unsigned FIFO_DEPTH    = 16;
  localparam int unsigned CLK_PERIOD_NS = 4;

  // Nap wake-up, a least time: rounded up
  localparam int unsigned NAP_WAKE_NS   = 350;
  localparam int unsigned NAP_WAKE_CYC  = (NAP_WAKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Reference settling after sleep
  localparam int unsigned REF_SETTLE_MS  = 4;
  localparam int unsigned REF_SETTLE_CYC =
    (REF_SETTLE_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Convert-to-clock lead time and conversion time; plain defaults
  localparam int unsigned LEAD_NS  = 20;
  localparam int unsigned LEAD_CYC = (LEAD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned CONVERT_REQUEST_NS  = 2000;
  localparam int unsigned CONVERT_REQUEST_CYC = (CONVERT_REQUEST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  localparam int unsigned NAP_PULSES   = 2;
  localparam int unsigned SLEEP_PULSES = 4;

  localparam logic        RST_POWER_ON = 1'h1;
  localparam logic        RST_SETTLED  = 1'h1;

  // Gray along active -> nap -> sleep -> wake -> active
  typedef enum logic [1:0] {
    PWR_ACTIVE = 2'h0,
    PWR_NAP    = 2'h1,
    PWR_SLEEP  = 2'h3,
    PWR_WAKE   = 2'h2
  } acr_pwr_t;

endpackage

/* rtl/acr_timer.sv */
module acr_timer #(
  parameter int unsigned CNT_W = 8
) (
  input  wire logic             sys_clk,
  input  wire logic             rst_b,
  input  wire logic             start,
  input  wire logic [CNT_W-1:0] load,
  output logic                  done
);
  import acr_pkg::*;

  if (CNT_W < 1 || CNT_W > 31) begin : g_bad_w
    $error("acr_timer: CNT_W out of range");
  end

  logic [CNT_W-1:0] cnt;

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt <= '0;
    end else if (start) begin
      cnt <= load;
    end else if (cnt != '0) begin
      cnt <= cnt - 1'b1;
    end
  end

  assign done = (cnt == '0);

endmodule

/* rtl/acr_fifo.sv */
module acr_fifo #(
  parameter int unsigned WIDTH = acr_pkg::WORD_W,
  parameter int unsigned DEPTH = acr_pkg::FIFO_DEPTH
) (
  input  wire logic             sys_clk,
  input  wire logic             rst_b,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  import acr_pkg::*;

  localparam int unsigned AW = $clog2(DEPTH);

  if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin : g_bad_fifo
    $error("acr_fifo: DEPTH must be a power of two >= 2");
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      count;
  logic             push;
  logic             pop;

  assign in_ready  = (count != (AW+1)'(DEPTH));
  assign out_valid = (count != '0);
  assign out_data  = mem[rd_ptr];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_ff @(posedge sys_clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
      if (push && !pop) begin
        count <= count + 1'b1;
      end else if (pop && !push) begin
        count <= count - 1'b1;
      end
    end
  end

endmodule

/* rtl/acr_top.sv */
module acr_top #(
  parameter int unsigned REF_SETTLE_CYC = acr_pkg::REF_SETTLE_CYC,
  parameter int unsigned CONVERT_REQUEST_CYC       = acr_pkg::CONVERT_REQUEST_CYC,
  parameter int unsigned LEAD_CYC       = acr_pkg::LEAD_CYC,
  parameter int unsigned FIFO_DEPTH     = acr_pkg::FIFO_DEPTH
) (
  input  wire logic                       sys_clk,
  input  wire logic                       rst_b,
  input  wire logic                       serial_clk,
  input  wire logic                       convert_request,
  input  wire logic [acr_pkg::DATA_W-1:0] adc_code,
  input  wire logic                       vss_below_gnd,
  input  wire logic                       vref_low,
  output logic                            serial_out,
  output logic                            reference_settled_flag,
  output logic                            core_power_on,
  output logic                            ref_power_on,
  output logic                            converting
);
  import acr_pkg::*;

  if (CONVERT_REQUEST_CYC < 1 || CONVERT_REQUEST_CYC > 65535) begin : g_bad_convert_request
    $error("acr_top: CONVERT_REQUEST_CYC out of range");
  end
  if (LEAD_CYC < 1 || LEAD_CYC > 255) begin : g_bad_lead
    $error("acr_top: LEAD_CYC out of range");
  end
  if (REF_SETTLE_CYC < 1 || REF_SETTLE_CYC > 16777215) begin : g_bad_settle
    $error("acr_top: REF_SETTLE_CYC out of range");
  end

  logic              sclk_q;
  logic              convert_request_q;
  logic              sclk_rise;
  logic              convert_request_rise;
  logic              convert_request_fall;
  acr_pwr_t          pwr_state;
  acr_pwr_t          next_pwr;
  logic [2:0]        pulse_cnt;
  logic              nap_start;
  logic              nap_done;
  logic              settle_start;
  logic              settle_done;
  logic              settle_wait;
  logic              ref_settled;
  logic              ref_ok;
  logic [15:0]       convert_request_cnt;
  logic              convert_request_ok;
  logic              convert_request_start;
  logic              convert_request_end;
  logic [DATA_W-1:0] coded;
  logic [WORD_W-1:0] cap_word;
  logic              fifo_in_ready;
  logic              fifo_out_valid;
  logic [WORD_W-1:0] fifo_out_data;
  logic              fifo_pop;
  logic              lead_pend;
  logic [7:0]        lead_cnt;
  logic              skip_edge;
  logic              shift_rise;
  logic              sh_busy;
  logic [3:0]        bits_left;
  logic [WORD_W-1:0] shreg;

  // Pins are synchronous; one stage gives the edge reference
  // Clock sampler resets to the idle high level, so release shows no false rise
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      sclk_q <= 1'h1;
      convert_request_q <= 1'h0;
    end else begin
      sclk_q <= serial_clk;
      convert_request_q <= convert_request;
    end
  end

  assign sclk_rise = serial_clk && !sclk_q;
  assign convert_request_rise = convert_request && !convert_request_q;
  assign convert_request_fall = !convert_request && convert_request_q;

  // Convert pulses are counted only while the serial clock stays low
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      pulse_cnt <= 3'h0;
    end else if (serial_clk) begin
      pulse_cnt <= 3'h0;
    end else if (convert_request_fall && pulse_cnt != 3'(SLEEP_PULSES)) begin
      pulse_cnt <= pulse_cnt + 3'h1;
    end
  end

  always_comb begin
    next_pwr     = pwr_state;
    nap_start    = 1'b0;
    settle_start = 1'b0;
    unique case (pwr_state)
      PWR_ACTIVE: begin
        if (!serial_clk && convert_request_fall && pulse_cnt == 3'(NAP_PULSES - 1)) begin
          next_pwr = PWR_NAP;
        end
      end
      PWR_NAP: begin
        if (sclk_rise) begin
          next_pwr  = PWR_WAKE;
          nap_start = 1'b1;
        end else if (!serial_clk && convert_request_fall && pulse_cnt == 3'(SLEEP_PULSES - 1)) begin
          next_pwr = PWR_SLEEP;
        end
      end
      PWR_SLEEP: begin
        if (sclk_rise) begin
          next_pwr     = PWR_WAKE;
          nap_start    = 1'b1;
          settle_start = 1'b1;
        end
      end
      PWR_WAKE: begin
        if (nap_done) begin
          next_pwr = PWR_ACTIVE;
        end
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      pwr_state <= PWR_ACTIVE;
    end else begin
      pwr_state <= next_pwr;
    end
  end

  acr_timer #(
    .CNT_W (8)
  ) u_nap_timer (
    .sys_clk (sys_clk),
    .rst_b   (rst_b),
    .start   (nap_start),
    .load    (8'(NAP_WAKE_CYC)),
    .done    (nap_done)
  );

  acr_timer #(
    .CNT_W (24)
  ) u_settle_timer (
    .sys_clk (sys_clk),
    .rst_b   (rst_b),
    .start   (settle_start),
    .load    (24'(REF_SETTLE_CYC)),
    .done    (settle_done)
  );

  // Sleep drops the reference; it is trusted again only after settling
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      settle_wait <= 1'h0;
      ref_settled <= RST_SETTLED;
    end else if (settle_start) begin
      settle_wait <= 1'h1;
    end else if (next_pwr == PWR_SLEEP) begin
      settle_wait <= 1'h0;
      ref_settled <= 1'h0;
    end else if (settle_wait && settle_done) begin
      settle_wait <= 1'h0;
      ref_settled <= 1'h1;
    end
  end

  assign ref_ok = ref_settled && !vref_low && pwr_state != PWR_SLEEP;

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      reference_settled_flag <= RST_SETTLED;
      ref_power_on           <= RST_POWER_ON;
      core_power_on          <= RST_POWER_ON;
    end else begin
      reference_settled_flag <= ref_ok;
      ref_power_on           <= (next_pwr != PWR_SLEEP);
      core_power_on          <= (next_pwr != PWR_SLEEP && next_pwr != PWR_NAP);
    end
  end

  // A word slot is reserved at start, so a full FIFO refuses the start
  assign convert_request_ok    = pwr_state == PWR_ACTIVE && !converting && fifo_in_ready;
  assign convert_request_start = convert_request_rise && convert_request_ok;
  assign convert_request_end   = converting && convert_request_cnt == 16'h0 && pwr_state == PWR_ACTIVE;

  // Offset-binary to two's complement is an MSB flip
  assign coded = vss_below_gnd ? {~adc_code[DATA_W-1], adc_code[DATA_W-2:0]}
                               : adc_code;

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      converting <= 1'h0;
      convert_request_cnt   <= 16'h0;
      cap_word   <= '0;
    end else if (convert_request_start) begin
      converting <= 1'h1;
      convert_request_cnt   <= 16'(CONVERT_REQUEST_CYC - 1);
      cap_word   <= {ref_ok, coded};
    end else if (pwr_state != PWR_ACTIVE || convert_request_end) begin
      // Power-down aborts a conversion in flight
      converting <= 1'h0;
    end else if (converting) begin
      convert_request_cnt <= convert_request_cnt - 16'h1;
    end
  end

  acr_fifo #(
    .WIDTH (WORD_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .sys_clk   (sys_clk),
    .rst_b     (rst_b),
    .in_valid  (convert_request_end),
    .in_ready  (fifo_in_ready),
    .in_data   (cap_word),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_pop),
    .out_data  (fifo_out_data)
  );

  // First clock rise after a late convert edge is not used
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      lead_pend <= 1'h0;
      lead_cnt  <= 8'h0;
    end else if (convert_request_start) begin
      lead_pend <= 1'h1;
      lead_cnt  <= 8'h0;
    end else begin
      if (sclk_rise) begin
        lead_pend <= 1'h0;
      end
      if (lead_cnt != 8'(LEAD_CYC)) begin
        lead_cnt <= lead_cnt + 8'h1;
      end
    end
  end

  assign skip_edge  = lead_pend && lead_cnt < 8'(LEAD_CYC);
  assign shift_rise = sclk_rise && !skip_edge && pwr_state == PWR_ACTIVE;
  assign fifo_pop   = shift_rise && !sh_busy && fifo_out_valid;

  // Data moves just after each used rise; host samples it two falling edges later, before the next rise
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      serial_out <= 1'h0;
      sh_busy    <= 1'h0;
      bits_left  <= 4'h0;
      shreg      <= '0;
    end else if (fifo_pop) begin
      serial_out <= fifo_out_data[WORD_W-1];
      shreg      <= {fifo_out_data[WORD_W-2:0], 1'b0};
      bits_left  <= 4'(DATA_W);
      sh_busy    <= 1'h1;
    end else if (shift_rise && sh_busy) begin
      serial_out <= shreg[WORD_W-1];
      shreg      <= {shreg[WORD_W-2:0], 1'b0};
      bits_left  <= bits_left - 4'h1;
      sh_busy    <= (bits_left != 4'h1);
    end else if (shift_rise) begin
      serial_out <= 1'h0;
    end
  end

  property p_nap_entry;
    @(posedge sys_clk) disable iff (!rst_b)
    (pwr_state == PWR_ACTIVE && !serial_clk && convert_request_fall && pulse_cnt == 3'h1)
      |=> pwr_state == PWR_NAP && !core_power_on;
  endproperty
  a_nap_entry: assert property (p_nap_entry) else $error("nap not entered");
  property p_sleep_entry;
    @(posedge sys_clk) disable iff (!rst_b)
    (pwr_state == PWR_NAP && !serial_clk && !sclk_rise && convert_request_fall && pulse_cnt == 3'h3)
      |=> pwr_state == PWR_SLEEP && !ref_power_on;
  endproperty
  a_sleep_entry: assert property (p_sleep_entry) else $error("sleep not entered");
  property p_nap_wake;
    @(posedge sys_clk) disable iff (!rst_b)
    (pwr_state == PWR_NAP && sclk_rise)
      |=> (pwr_state == PWR_WAKE && ref_power_on) [*8] ##81 pwr_state == PWR_WAKE ##1 pwr_state == PWR_ACTIVE;
  endproperty
  a_nap_wake: assert property (p_nap_wake) else $error("nap wake timing wrong");
  property p_sleep_wake;
    @(posedge sys_clk) disable iff (!rst_b)
    (pwr_state == PWR_SLEEP && sclk_rise) |=> pwr_state == PWR_WAKE ##1 !reference_settled_flag;
  endproperty
  a_sleep_wake: assert property (p_sleep_wake) else $error("sleep wake wrong");
  // Power output switches on the same edge as the state, the flag trails it by one
  property p_sleep_flag;
    @(posedge sys_clk) disable iff (!rst_b)
    pwr_state == PWR_SLEEP |-> !ref_power_on ##1 !reference_settled_flag;
  endproperty
  a_sleep_flag: assert property (p_sleep_flag) else $error("flag high in sleep");
  property p_vref_low;
    @(posedge sys_clk) disable iff (!rst_b)
    vref_low |=> !reference_settled_flag;
  endproperty
  a_vref_low: assert property (p_vref_low) else $error("flag high with low reference");
  property p_busy_ignore;
    @(posedge sys_clk) disable iff (!rst_b)
    (converting && convert_request_rise && convert_request_cnt != 16'h0 && pwr_state == PWR_ACTIVE)
      |=> converting && convert_request_cnt == $past(convert_request_cnt) - 16'h1;
  endproperty
  a_busy_ignore: assert property (p_busy_ignore) else $error("conversion restarted");
  property p_start;
    @(posedge sys_clk) disable iff (!rst_b)
    (convert_request_rise && pwr_state == PWR_ACTIVE && !converting && fifo_in_ready)
      |=> converting && cap_word[WORD_W-1] == $past(ref_ok);
  endproperty
  a_start: assert property (p_start) else $error("conversion not started");
  property p_coding;
    @(posedge sys_clk) disable iff (!rst_b)
    convert_request_start |=> cap_word[DATA_W-1] == ($past(adc_code[DATA_W-1]) ^ $past(vss_below_gnd))
      && cap_word[DATA_W-2:0] == $past(adc_code[DATA_W-2:0]);
  endproperty
  a_coding: assert property (p_coding) else $error("output coding wrong");
  property p_skip;
    @(posedge sys_clk) disable iff (!rst_b)
    (sclk_rise && skip_edge) |=> $stable(serial_out) && $stable(bits_left);
  endproperty
  a_skip: assert property (p_skip) else $error("late convert edge not delayed");
  property p_dout_edge;
    @(posedge sys_clk) disable iff (!rst_b)
    $changed(serial_out) |-> $past(sclk_rise);
  endproperty
  a_dout_edge: assert property (p_dout_edge) else $error("output moved off clock edge");
  property p_flag_first;
    @(posedge sys_clk) disable iff (!rst_b)
    fifo_pop |=> serial_out == $past(fifo_out_data[WORD_W-1]) && bits_left == 4'hc;
  endproperty
  a_flag_first: assert property (p_flag_first) else $error("flag not sent first");
  property p_msb_next;
    @(posedge sys_clk) disable iff (!rst_b)
    (shift_rise && sh_busy && bits_left == 4'hc) |=> serial_out == $past(shreg[WORD_W-1]);
  endproperty
  a_msb_next: assert property (p_msb_next) else $error("result msb not next");

  c_word:  cover property (@(posedge sys_clk) disable iff (!rst_b) sh_busy && bits_left == 4'h1 && shift_rise);
  c_nap:   cover property (@(posedge sys_clk) disable iff (!rst_b) pwr_state == PWR_NAP && sclk_rise);
  c_sleep: cover property (@(posedge sys_clk) disable iff (!rst_b) pwr_state == PWR_SLEEP && sclk_rise);
  c_full:  cover property (@(posedge sys_clk) disable iff (!rst_b) convert_request_rise && !fifo_in_ready);

endmodule

/* sim/acr_host_model.sv */
module acr_host_model (
  input  wire logic sys_clk,
  input  wire logic serial_out,
  output logic      serial_clk,
  output logic      convert_request
);
  timeunit 1ns;
  timeprecision 1ps;

  // Clock idles high so that convert pulses are not taken as a power pattern
  initial begin
    serial_clk      = 1'h1;
    convert_request = 1'h0;
  end

  task automatic wait_neg(input int n);
    repeat (n) @(negedge sys_clk);
  endtask

  task automatic pulse_convert(input int high_cyc);
    convert_request = 1'h1;
    wait_neg(high_cyc);
    convert_request = 1'h0;
    wait_neg(2);
  endtask

  task automatic power_pattern(input int pulses);
    serial_clk = 1'h0;
    repeat (pulses) pulse_convert(2);
  endtask

  // One rise; the bit it launches is settled two falling edges later
  task automatic clock_bit(output logic b);
    serial_clk = 1'h0;
    wait_neg(1);
    serial_clk = 1'h1;
    wait_neg(2);
    b = serial_out;
  endtask

  task automatic read_word(output logic [acr_pkg::WORD_W-1:0] w);
    logic b;
    w = '0;
    for (int i = 0; i < acr_pkg::WORD_W; i++) begin
      clock_bit(b);
      w = {w[acr_pkg::WORD_W-2:0], b};
    end
  endtask

  // Clock rise placed gap cycles after the convert rise
  task automatic convert_then_clock(input int gap);
    serial_clk = 1'h0;
    wait_neg(1);
    convert_request = 1'h1;
    wait_neg(gap);
    serial_clk = 1'h1;
    wait_neg(2);
    convert_request = 1'h0;
    wait_neg(2);
  endtask
endmodule

/* sim/testbench.sv */
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import acr_pkg::*;

  localparam int REF_CYC = 200;
  localparam int CONVERT_REQUEST_C  = 20;
  localparam int DEPTH   = FIFO_DEPTH;

  logic                sys_clk;
  logic                rst_b;
  logic                serial_clk;
  logic                convert_request;
  logic [DATA_W-1:0]   adc_code;
  logic                vss_below_gnd;
  logic                vref_low;
  logic                serial_out;
  logic                reference_settled_flag;
  logic                core_power_on;
  logic                ref_power_on;
  logic                converting;
  int                  errors;
  int                  samples_checked;
  int                  seed = 70;
  logic [DATA_W-1:0]   corners [5] = '{12'h000, 12'hfff, 12'h800, 12'h7ff, 12'h001};

  acr_top #(
    .REF_SETTLE_CYC (REF_CYC),
    .CONVERT_REQUEST_CYC       (CONVERT_REQUEST_C)
  ) u_acr_top (
    .sys_clk                (sys_clk),
    .rst_b                  (rst_b),
    .serial_clk             (serial_clk),
    .convert_request        (convert_request),
    .adc_code               (adc_code),
    .vss_below_gnd          (vss_below_gnd),
    .vref_low               (vref_low),
    .serial_out             (serial_out),
    .reference_settled_flag (reference_settled_flag),
    .core_power_on          (core_power_on),
    .ref_power_on           (ref_power_on),
    .converting             (converting)
  );

  acr_host_model host (
    .sys_clk         (sys_clk),
    .serial_out      (serial_out),
    .serial_clk      (serial_clk),
    .convert_request (convert_request)
  );

  initial begin
    sys_clk = 1'h0;
    forever #2 sys_clk = ~sys_clk;
  end

  task automatic chk_bit(input logic got, input logic exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t %s got %b exp %b", $time, what, got, exp);
    end
  endtask

  task automatic chk_word(input logic [WORD_W-1:0] got, input logic [WORD_W-1:0] exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic chk_num(input int got, input int exp, input string what);
    samples_checked++;
    if (got != exp) begin
      errors++;
      $display("[ERR] %0t %s got %0d exp %0d", $time, what, got, exp);
    end
  endtask

  // Bipolar coding is offset binary with the top bit turned over
  function automatic logic [WORD_W-1:0] exp_word(input logic [DATA_W-1:0] code, input logic bip,
                                                 input logic ok);
    return {ok, code ^ {bip, {(DATA_W - 1){1'h0}}}};
  endfunction

  task automatic do_convert(input logic [DATA_W-1:0] code, input logic bip, input logic low,
                            input logic ok, input logic extra, input logic take);
    int n;
    adc_code      = code;
    vss_below_gnd = bip;
    vref_low      = low;
    host.pulse_convert(2);
    adc_code = ~code;
    chk_bit(converting, take, "converting");
    n = 4;
    if (extra) begin
      host.pulse_convert(2);
      n = n + 4;
    end
    while (take && converting === 1'h1 && n < 200) begin
      @(negedge sys_clk);
      n++;
    end
    // Counted from the driving edge: busy is seen low CONVERT_REQUEST_CYC + 1 falling edges later
    if (take) chk_num(n, CONVERT_REQUEST_C + 1, "conversion cycles");
    chk_bit(reference_settled_flag, ok, "ready flag");
  endtask

  task automatic convert_request_read(input logic [DATA_W-1:0] code, input logic bip, input logic low);
    logic [WORD_W-1:0] w;
    do_convert(code, bip, low, !low, 1'h0, 1'h1);
    host.read_word(w);
    chk_word(w, exp_word(code, bip, !low), "word");
  endtask

  task automatic end_of_test;
    $display("checks %0d errors %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge sys_clk);
    errors++;
    $display("[ERR] %0t watchdog expired", $time);
    end_of_test();
  end

  initial begin
    logic [DATA_W-1:0] code;
    logic [WORD_W-1:0] w;
    logic              b;
    logic              bp;
    logic [WORD_W-1:0] q [$];
    rst_b         = 1'h0;
    adc_code      = '0;
    vss_below_gnd = 1'h0;
    vref_low      = 1'h0;
    errors          = 0;
    samples_checked = 0;
    repeat (10) @(negedge sys_clk);
    chk_bit(core_power_on, 1'h1, "reset core");
    chk_bit(ref_power_on, 1'h1, "reset ref");
    chk_bit(reference_settled_flag, 1'h1, "reset flag");
    chk_bit(converting, 1'h0, "reset converting");
    chk_bit(serial_out, 1'h0, "reset data");
    repeat (10) @(negedge sys_clk);
    rst_b = 1'h1;
    host.wait_neg(1);
    for (int i = 0; i < 16; i++) begin
      if (i < 10) begin
        convert_request_read(corners[i / 2], 1'(i % 2), 1'h0);
      end else begin
        convert_request_read(DATA_W'($random(seed)), 1'($random(seed)), 1'($random(seed)));
      end
    end
    // Clock rise too soon after the convert rise is not used
    convert_request_read(12'h555, 1'h0, 1'h0);
    adc_code = 12'h0f0;
    host.convert_then_clock(1);
    chk_bit(serial_out, 1'h1, "skipped rise");
    for (int n = 0; n < 100 && converting === 1'h1; n++) @(negedge sys_clk);
    host.read_word(w);
    chk_word(w, exp_word(12'h0f0, 1'h0, 1'h1), "late word");
    // Fill the buffer while nobody reads, one more is refused
    for (int i = 0; i <= DEPTH; i++) begin
      code = DATA_W'($random(seed));
      bp   = 1'($random(seed));
      do_convert(code, bp, 1'h0, 1'h1, i == 0, i < DEPTH);
      if (i < DEPTH) q.push_back(exp_word(code, bp, 1'h1));
    end
    foreach (q[i]) begin
      host.read_word(w);
      chk_word(w, q[i], "buffered word");
    end
    host.clock_bit(b);
    chk_bit(b, 1'h0, "empty buffer");
    host.power_pattern(2);
    chk_bit(core_power_on, 1'h0, "nap core");
    chk_bit(ref_power_on, 1'h1, "nap ref");
    do_convert(12'h123, 1'h0, 1'h0, 1'h1, 1'h0, 1'h0);
    host.clock_bit(b);
    chk_bit(core_power_on, 1'h1, "wake core");
    // Last edge still inside the wake-up time: this convert must be refused
    host.wait_neg(NAP_WAKE_CYC - 1);
    do_convert(12'h456, 1'h0, 1'h0, 1'h1, 1'h0, 1'h0);
    host.wait_neg(8);
    convert_request_read(12'h789, 1'h1, 1'h0);
    host.power_pattern(4);
    host.wait_neg(2);
    chk_bit(core_power_on, 1'h0, "sleep core");
    chk_bit(ref_power_on, 1'h0, "sleep ref");
    chk_bit(reference_settled_flag, 1'h0, "sleep flag");
    host.clock_bit(b);
    host.wait_neg(90);
    do_convert(12'habc, 1'h0, 1'h0, 1'h0, 1'h0, 1'h1);
    host.read_word(w);
    chk_word(w, exp_word(12'habc, 1'h0, 1'h0), "settling word");
    // Flag rises REF_CYC + 2 edges after the waking rise is sampled
    host.wait_neg(50);
    chk_bit(reference_settled_flag, 1'h0, "settling flag");
    host.wait_neg(1);
    chk_bit(reference_settled_flag, 1'h1, "settled flag");
    end_of_test();
  end
endmodule
